// *** verilog/cmp_ctrl_pkg.sv ***
// Purpose: constants for the comparator control register block
// Assumes: 8-bit special-function register bus
// Notes: field positions and reset value of the control register
package cmp_ctrl_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hf8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_ON = 7;
  localparam int BIT_LEVEL = 6;
  localparam int BIT_RISE = 5;
  localparam int BIT_FALL = 4;
  localparam int POS_HYS_LO = 2;
  localparam int NEG_HYS_LO = 0;
  localparam int SYNC_STAGES = 2;
endpackage

// *** verilog/level_sync.sv ***
// Purpose: multi-stage synchroniser for one asynchronous level
// Assumes: single clock, asynchronous active-low reset
// Notes: first stage is read only by the next stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int STAGES = 2
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] chain_q;

  // shift the level through the chain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_q[STAGES-1];
endmodule
`default_nettype wire

// *** verilog/comparator_edge_flag_control.sv ***
// Purpose: control register and edge flags around an analog comparator
// Assumes: sfr bus synchronous to core_clk; comparator output asynchronous
// Notes: bit writes arrive as a byte write with the other bits unchanged
`timescale 1ns/1ps
`default_nettype none
module comparator_edge_flag_control (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_raw_out,
  output logic comparator_on,
  output logic [1:0] pos_hysteresis_sel,
  output logic [1:0] neg_hysteresis_sel,
  output logic rise_seen_flag,
  output logic fall_seen_flag
);
  logic level_sync_w;
  logic level_q;
  logic rise_det_q;
  logic fall_det_q;
  logic [7:0] rdata_q;
  logic hit_w;
  logic wr_w;
  logic rise_d;
  logic fall_d;
  logic [7:0] read_w;

  level_sync #(
    .STAGES(cmp_ctrl_pkg::SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(cmp_raw_out),
    .sync_out(level_sync_w)
  );

  // address decode
  assign hit_w = (sfr_addr == cmp_ctrl_pkg::CTRL_ADDR);
  assign wr_w = hit_w && sfr_wr;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= 1'b0;
      rise_det_q <= 1'b0;
      fall_det_q <= 1'b0;
    end else begin
      level_q <= level_sync_w;
      rise_det_q <= level_sync_w && !level_q;
      fall_det_q <= !level_sync_w && level_q;
    end
  end

  assign rise_d = rise_det_q
    || (wr_w ? sfr_wdata[cmp_ctrl_pkg::BIT_RISE] : rise_seen_flag);
  assign fall_d = fall_det_q
    || (wr_w ? sfr_wdata[cmp_ctrl_pkg::BIT_FALL] : fall_seen_flag);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_seen_flag <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::BIT_RISE];
      fall_seen_flag <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::BIT_FALL];
    end else begin
      rise_seen_flag <= rise_d;
      fall_seen_flag <= fall_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator_on <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::BIT_ON];
      pos_hysteresis_sel <=
        cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::POS_HYS_LO +: 2];
      neg_hysteresis_sel <=
        cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::NEG_HYS_LO +: 2];
    end else if (wr_w) begin
      comparator_on <= sfr_wdata[cmp_ctrl_pkg::BIT_ON];
      pos_hysteresis_sel <=
        sfr_wdata[cmp_ctrl_pkg::POS_HYS_LO +: 2];
      neg_hysteresis_sel <=
        sfr_wdata[cmp_ctrl_pkg::NEG_HYS_LO +: 2];
    end
  end

  assign read_w = {comparator_on, level_sync_w, rise_seen_flag,
                   fall_seen_flag, pos_hysteresis_sel, neg_hysteresis_sel};

  // registered read data, zero off-address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= (hit_w && sfr_rd) ? read_w : 8'h00;
    end
  end

  assign sfr_rdata = rdata_q;

  property p_rise_sets;
    @(posedge core_clk) disable iff (!arst_n)
      (level_sync_w && !level_q) |=> ##1 rise_seen_flag;
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rise edge did not set flag");

  property p_fall_sets;
    @(posedge core_clk) disable iff (!arst_n)
      (!level_sync_w && level_q) |=> ##1 fall_seen_flag;
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("fall edge did not set flag");

  property p_rise_sticky;
    @(posedge core_clk) disable iff (!arst_n)
      (rise_seen_flag && !wr_w) |=> rise_seen_flag;
  endproperty
  a_rise_sticky: assert property (p_rise_sticky)
    else $error("rise flag dropped without write");

  property p_fall_sticky;
    @(posedge core_clk) disable iff (!arst_n)
      (fall_seen_flag && !wr_w) |=> fall_seen_flag;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky)
    else $error("fall flag dropped without write");

  property p_level_read;
    @(posedge core_clk) disable iff (!arst_n)
      (hit_w && sfr_rd) |=> sfr_rdata[6] == $past(level_sync_w);
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level bit read wrong");

  property p_on_write;
    @(posedge core_clk) disable iff (!arst_n)
      wr_w |=> comparator_on == $past(sfr_wdata[7]);
  endproperty
  a_on_write: assert property (p_on_write)
    else $error("enable bit not written");

  property p_pos_write;
    @(posedge core_clk) disable iff (!arst_n)
      wr_w |=> pos_hysteresis_sel == $past(sfr_wdata[3:2]);
  endproperty
  a_pos_write: assert property (p_pos_write)
    else $error("positive hysteresis not written");

  property p_neg_hold;
    @(posedge core_clk) disable iff (!arst_n)
      !wr_w |=> $stable(neg_hysteresis_sel);
  endproperty
  a_neg_hold: assert property (p_neg_hold)
    else $error("negative hysteresis changed without write");

  // rise flag not set without a rise edge, except by a write
  property p_rise_cause;
    @(posedge core_clk) disable iff (!arst_n)
      ($rose(rise_seen_flag) && !$past(wr_w)) |-> $past(rise_det_q);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("rise flag set without edge");

  // fall flag needs a fall edge or a write
  property p_fall_cause;
    @(posedge core_clk) disable iff (!arst_n)
      ($rose(fall_seen_flag) && !$past(wr_w)) |-> $past(fall_det_q);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("fall flag set without edge");

  property p_rise_once;
    @(posedge core_clk) disable iff (!arst_n)
      rise_det_q |=> !rise_det_q;
  endproperty
  a_rise_once: assert property (p_rise_once)
    else $error("rise detect pulse held too long");

  property p_set_wins;
    @(posedge core_clk) disable iff (!arst_n)
      (rise_det_q && wr_w) |=> rise_seen_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clearing write lost a rise edge");

  property p_neg_write;
    @(posedge core_clk) disable iff (!arst_n)
      wr_w |=> neg_hysteresis_sel == $past(sfr_wdata[1:0]);
  endproperty
  a_neg_write: assert property (p_neg_write)
    else $error("negative hysteresis not written");

  // read data zero outside a read
  property p_rdata_idle;
    @(posedge core_clk) disable iff (!arst_n)
      !(hit_w && sfr_rd) |=> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
endmodule
`default_nettype wire

// *** verification/comparator_edge_flag_control_tb.sv ***
// Purpose: self-checking bench for the comparator control block
// Assumes: inputs driven on the falling edge of core_clk
// Notes: edge flags awaited under a bounded count
`timescale 1ns/1ps
`default_nettype none
module comparator_edge_flag_control_tb;
  localparam logic [7:0] A = cmp_ctrl_pkg::CTRL_ADDR;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic cmp_raw_out = 1'b0;
  logic [7:0] sfr_rdata;
  logic comparator_on;
  logic [1:0] pos_hysteresis_sel;
  logic [1:0] neg_hysteresis_sel;
  logic rise_seen_flag;
  logic fall_seen_flag;
  logic [7:0] rv;
  int bad_count = 0;
  int samples_checked = 0;
  // outputs packed in register bit order, bit 6 left zero
  wire [7:0] outs = {comparator_on, 1'b0, rise_seen_flag, fall_seen_flag,
                     pos_hysteresis_sel, neg_hysteresis_sel};

  // 4 ns clock
  always #2 core_clk = ~core_clk;

  comparator_edge_flag_control uut (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .cmp_raw_out(cmp_raw_out),
    .comparator_on(comparator_on), .pos_hysteresis_sel(pos_hysteresis_sel),
    .neg_hysteresis_sel(neg_hysteresis_sel),
    .rise_seen_flag(rise_seen_flag), .fall_seen_flag(fall_seen_flag));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    rv = sfr_rdata;
  endtask

  // move the comparator level and time the matching flag
  task automatic edge_to(input logic lvl);
    int n;
    n = 0;
    @(negedge core_clk);
    cmp_raw_out = lvl;
    while ((lvl ? rise_seen_flag : fall_seen_flag) !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    chk("flag latency", 8'h04, 8'(n));
    if (n == 8) report_and_stop();
  endtask

  task automatic t_reset();
    rd(A);
    chk("reset value", cmp_ctrl_pkg::CTRL_RESET, rv);
    $display("test reset done");
  endtask

  // every hysteresis code, enable both ways, bit 6 write ignored
  task automatic t_fields();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[0], 1'b1, 2'h0, i[1:0], 2'(3 - i)};
      wr(A, d);
      chk("fields", d & 8'hbf, outs);
      rd(A);
      chk("readback", d & 8'hbf, rv);
    end
    wr(8'hf7, 8'hff);
    rd(8'hf7);
    chk("unmapped read", 8'h00, rv);
    rd(A);
    chk("after unmapped", d & 8'hbf, rv);
    $display("test fields done");
  endtask

  task automatic t_edges();
    wr(A, 8'h00);
    edge_to(1'b1);
    rd(A);
    chk("after rise", 8'h60, rv);
    edge_to(1'b0);
    rd(A);
    chk("after fall", 8'h30, rv);
    wr(A, 8'h00);
    repeat (6) @(negedge core_clk);
    rd(A);
    chk("cleared", 8'h00, rv);
    $display("test edges done");
  endtask

  // clear racing a rise, write-one sets, then a reset in mid-run
  task automatic t_race_reset();
    @(negedge core_clk);
    cmp_raw_out = 1'b1;
    repeat (2) @(negedge core_clk);
    wr(A, 8'h00);
    chk("set beats clear", 8'h20, outs);
    wr(A, 8'hbf);
    chk("write ones", 8'hbf, outs);
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("in reset", 8'h00, outs);
    arst_n = 1'b1;
    @(negedge core_clk);
    chk("first edge after reset", 8'h00, outs);
    repeat (3) @(negedge core_clk);
    chk("rise after reset", 8'h20, outs);
    rd(A);
    chk("read after reset", 8'h60, rv);
    $display("test race_reset done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    t_reset();
    t_fields();
    t_edges();
    t_race_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
